//--- pkg/sps_pkg.sv
// Shared constants, settings layout and pin bundles of the programmable
// synchronous memory port.
// Assumes one clock domain (clk_in) with external output clocks sampled in.
package sps_pkg;

   // Structure
   localparam int SPS_PORTS = 2;
   localparam int SPACES = 4;
   localparam int SPACE_W = 2;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 32;
   localparam int LEN_W = 4;
   localparam int PH_W = 6;
   localparam int INST_WIDE = 0;
   localparam int INST_NARROW = 1;

   // Setting encodings
   localparam logic MODE_ADDR_STROBE = 1'b0;
   localparam logic MODE_READ_ENABLE = 1'b1;
   localparam logic SEL_CLOCK_ONE = 1'b0;
   localparam logic SEL_CLOCK_TWO = 1'b1;
   localparam logic [PH_W-1:0] PH_START = 6'h00;
   localparam logic [PH_W-1:0] PH_STEP = 6'h01;

   // Per-space secondary control
   typedef struct packed {
      logic [1:0] read_latency_sel;
      logic [1:0] write_latency_sel;
      logic chip_enable_extend;
      logic strobe_as_read_enable;
      logic sync_clock_select;
   } sps_sec_s;

   // Access request; len is the word count minus one
   typedef struct packed {
      logic valid;
      logic write;
      logic [SPACE_W-1:0] space;
      logic [ADDR_W-1:0] addr;
      logic [LEN_W-1:0] len;
   } sps_req_s;

   // Memory-side pins; the shared strobe is the address strobe or,
   // in read-enable mode, the fifo read enable
   typedef struct packed {
      logic [SPACES-1:0] space_chip_enable_n;
      logic sync_address_strobe_n;
      logic sync_output_enable_n;
      logic sync_write_enable_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic data_oe;
   } sps_pins_s;

   // Read data returned to the requester
   typedef struct packed {
      logic valid;
      logic [DATA_W-1:0] data;
   } sps_rd_s;

   // Reset values
   localparam sps_pins_s PINS_IDLE = '{
      space_chip_enable_n: 4'hf,
      sync_address_strobe_n: 1'b1,
      sync_output_enable_n: 1'b1,
      sync_write_enable_n: 1'b1,
      addr: 20'h00000,
      data: 32'h00000000,
      data_oe: 1'b0
   };
   localparam sps_rd_s RD_IDLE = '{valid: 1'b0, data: 32'h00000000};
   localparam sps_sec_s SEC_RESET = 7'h00;

endpackage

//--- rtl/sps_clk_edge.sv
// Samples one external output clock into clk_in and flags its rising edges.
// Assumes the sampled clock is several clk_in periods long.
`timescale 1ns/1ps
module sps_clk_edge
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Sampled clock and its edge
   input wire logic link_clk_in,
   output logic rise_out
);

   logic s1_r, s2_r, s3_r;
   logic level_r, level_nxt;
   logic rise_r, rise_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // A change counts once the second and third stages agree
   always_comb
   begin
      level_nxt = level_r;
      rise_nxt = 1'b0;
      if (s2_r == s3_r)
      begin
         level_nxt = s3_r;
         rise_nxt = s3_r & ~level_r;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         level_r <= 1'b0;
         rise_r <= 1'b0;
      end
      else
      begin
         s1_r <= link_clk_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         level_r <= level_nxt;
         rise_r <= rise_nxt;
      end
   end

   assign rise_out = rise_r;

endmodule

//--- rtl/sps_port.sv
// Two identical programmable synchronous memory port engines.
// Assumes requests and write data come from logic on clk_in and the two
// external output clocks arrive from outside the clk_in domain.
`timescale 1ns/1ps
module sps_port
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // External output clocks
   input wire logic ext_clock_out_one_in,
   input wire logic ext_clock_out_two_in,
   // Per-space secondary control, per instance
   input sps_pkg::sps_sec_s space_secondary_control_in [sps_pkg::SPS_PORTS][sps_pkg::SPACES],
   // Requests and write data
   input sps_pkg::sps_req_s req_in [sps_pkg::SPS_PORTS],
   input wire logic [sps_pkg::DATA_W-1:0] wr_data_in [sps_pkg::SPS_PORTS],
   output logic req_take_out [sps_pkg::SPS_PORTS],
   output logic wr_data_take_out [sps_pkg::SPS_PORTS],
   output logic busy_out [sps_pkg::SPS_PORTS],
   // Read data
   input wire logic [sps_pkg::DATA_W-1:0] rd_data_in [sps_pkg::SPS_PORTS],
   output sps_pkg::sps_rd_s rd_out [sps_pkg::SPS_PORTS],
   // Memory pins
   output sps_pkg::sps_pins_s pins_out [sps_pkg::SPS_PORTS]
);

   import sps_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_DESELECT} sps_state_e;

   logic edge_one;
   logic edge_two;

   ////////////////////////////////////////////////////////////////////////////
   // Edge finders for the two output clocks

   sps_clk_edge u_edge_one
   (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .link_clk_in(ext_clock_out_one_in),
      .rise_out(edge_one)
   );

   sps_clk_edge u_edge_two
   (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .link_clk_in(ext_clock_out_two_in),
      .rise_out(edge_two)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic pick_edge(input logic sel, input logic e1, input logic e2);
      pick_edge = (sel == SEL_CLOCK_TWO) ? e2 : e1;
   endfunction

   // Pin values for link cycle p of an access
   function automatic sps_pins_s pins_for(input logic [PH_W-1:0] p, input sps_sec_s s,
                                          input sps_req_s r, input logic [DATA_W-1:0] wd);
      sps_pins_s o;
      logic [PH_W-1:0] words;
      logic [PH_W-1:0] wl;
      logic [PH_W-1:0] rl;
      logic issue;
      logic oe;
      logic ce;
      o = PINS_IDLE;
      words = PH_W'(r.len) + PH_STEP;
      wl = PH_W'(s.write_latency_sel);
      rl = PH_W'(s.read_latency_sel);
      issue = p < words;
      oe = ~r.write & (p < words + rl);
      if (s.chip_enable_extend)
         ce = r.write ? issue : oe;
      else
         ce = issue;
      o.space_chip_enable_n[r.space] = ~ce;
      o.addr = r.addr + ADDR_W'(p);
      o.sync_output_enable_n = ~oe;
      o.sync_write_enable_n = ~(r.write & issue);
      if (r.write)
         o.sync_address_strobe_n = ~(issue & (s.strobe_as_read_enable == MODE_ADDR_STROBE));
      else
         o.sync_address_strobe_n = ~issue;
      o.data_oe = r.write & (p >= wl) & (p < wl + words);
      o.data = o.data_oe ? wd : 32'h00000000;
      pins_for = o;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Engines, one per instance

   for (genvar g = 0; g < SPS_PORTS; g++)
   begin : g_inst
      sps_state_e st_r, st_nxt;
      sps_sec_s cur_r, cur_nxt;
      sps_req_s acc_r, acc_nxt;
      logic [PH_W-1:0] ph_r, ph_nxt;
      sps_pins_s pins_r, pins_nxt;
      sps_rd_s rd_r, rd_nxt;
      logic take_r, take_nxt;
      logic wtake_r, wtake_nxt;
      logic busy_r, busy_nxt;
      sps_sec_s req_sec;
      logic req_edge;
      logic cur_edge;
      logic [PH_W-1:0] last_ph;
      logic [DATA_W-1:0] rd_s1_r, rd_s2_r, rd_s3_r;
      logic [DATA_W-1:0] rd_held_r, rd_held_nxt;

      always_comb
      begin
         // Read bus passes three stages; a word counts once the last two agree
         rd_held_nxt = (rd_s2_r == rd_s3_r) ? rd_s3_r : rd_held_r;
         req_sec = space_secondary_control_in[g][req_in[g].space];
         req_edge = pick_edge(req_sec.sync_clock_select, edge_one, edge_two);
         cur_edge = pick_edge(cur_r.sync_clock_select, edge_one, edge_two);
         if (acc_r.write)
            last_ph = PH_W'(cur_r.write_latency_sel) + PH_W'(acc_r.len) + PH_STEP;
         else
            last_ph = PH_W'(cur_r.read_latency_sel) + PH_W'(acc_r.len) + PH_STEP;
         st_nxt = st_r;
         cur_nxt = cur_r;
         acc_nxt = acc_r;
         ph_nxt = ph_r;
         pins_nxt = pins_r;
         rd_nxt = RD_IDLE;
         take_nxt = 1'b0;
         wtake_nxt = 1'b0;
         busy_nxt = busy_r;
         unique case (st_r)
            ST_IDLE:
            begin
               if (req_in[g].valid && req_edge)
               begin
                  cur_nxt = req_sec;
                  acc_nxt = req_in[g];
                  pins_nxt = pins_for(PH_START, req_sec, req_in[g], wr_data_in[g]);
                  wtake_nxt = pins_nxt.data_oe;
                  ph_nxt = PH_STEP;
                  take_nxt = 1'b1;
                  busy_nxt = 1'b1;
                  st_nxt = ST_BUSY;
               end
            end
            ST_BUSY:
            begin
               if (cur_edge)
               begin
                  if (!acc_r.write && ph_r > PH_W'(cur_r.read_latency_sel))
                  begin
                     rd_nxt.valid = 1'b1;
                     rd_nxt.data = rd_held_nxt;
                  end
                  pins_nxt = pins_for(ph_r, cur_r, acc_r, wr_data_in[g]);
                  wtake_nxt = pins_nxt.data_oe;
                  ph_nxt = ph_r + PH_STEP;
                  if (ph_r == last_ph)
                  begin
                     if (cur_r.strobe_as_read_enable == MODE_ADDR_STROBE)
                     begin
                        pins_nxt.sync_address_strobe_n = 1'b0;
                        st_nxt = ST_DESELECT;
                     end
                     else
                     begin
                        busy_nxt = 1'b0;
                        st_nxt = ST_IDLE;
                     end
                  end
               end
            end
            ST_DESELECT:
            begin
               if (cur_edge)
               begin
                  pins_nxt = PINS_IDLE;
                  busy_nxt = 1'b0;
                  st_nxt = ST_IDLE;
               end
            end
         endcase
      end

      always_ff @(posedge clk_in or negedge rst_b_in)
      begin
         if (!rst_b_in)
         begin
            st_r <= ST_IDLE;
            cur_r <= SEC_RESET;
            acc_r <= '0;
            ph_r <= PH_START;
            pins_r <= PINS_IDLE;
            rd_r <= RD_IDLE;
            take_r <= 1'b0;
            wtake_r <= 1'b0;
            busy_r <= 1'b0;
            rd_s1_r <= '0;
            rd_s2_r <= '0;
            rd_s3_r <= '0;
            rd_held_r <= '0;
         end
         else
         begin
            st_r <= st_nxt;
            cur_r <= cur_nxt;
            acc_r <= acc_nxt;
            ph_r <= ph_nxt;
            pins_r <= pins_nxt;
            rd_r <= rd_nxt;
            take_r <= take_nxt;
            wtake_r <= wtake_nxt;
            busy_r <= busy_nxt;
            rd_s1_r <= rd_data_in[g];
            rd_s2_r <= rd_s1_r;
            rd_s3_r <= rd_s2_r;
            rd_held_r <= rd_held_nxt;
         end
      end

      assign pins_out[g] = pins_r;
      assign rd_out[g] = rd_r;
      assign req_take_out[g] = take_r;
      assign wr_data_take_out[g] = wtake_r;
      assign busy_out[g] = busy_r;
   end

endmodule

//--- tb/sps_mem_model.sv
// Behavioural synchronous memory on the far side of one port.
// Assumes one pins bundle and the clock that the used space selects.
`timescale 1ns/1ps
module sps_mem_model
(
   // Link clock and latency
   input wire logic link_clk_in,
   input wire logic [1:0] lat_in,
   // Pins and read data bus
   input sps_pkg::sps_pins_s pins_in,
   output logic [sps_pkg::DATA_W-1:0] rd_data_out
);
   import sps_pkg::*;
   logic [DATA_W:0] pipe [3];
   logic [DATA_W:0] cur;
   logic [DATA_W:0] pick;
   initial
   begin
      pipe = '{default: '0};
      rd_data_out = 32'h0f0f0f0f;
   end
   // Read command: a space enabled, strobe low, write enable high
   assign cur = {!(&pins_in.space_chip_enable_n) && !pins_in.sync_address_strobe_n &&
      pins_in.sync_write_enable_n, 12'h5a0, pins_in.addr};
   assign pick = (lat_in == 2'h0) ? cur : pipe[lat_in - 2'h1];
   // Released bus shows the inverse of its last value
   always @(posedge link_clk_in)
   begin
      pipe <= '{cur, pipe[0], pipe[1]};
      rd_data_out <= pick[DATA_W] ? pick[DATA_W-1:0] : ~rd_data_out;
   end
endmodule

//--- tb/sps_chk.sv
// Port assertions on the wide instance; the narrow one is identical.
// Assumes binding into sps_port.
`timescale 1ns/1ps
module sps_chk
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Watched outputs
   input logic req_take_out [sps_pkg::SPS_PORTS],
   input logic wr_data_take_out [sps_pkg::SPS_PORTS],
   input logic busy_out [sps_pkg::SPS_PORTS],
   input sps_pkg::sps_rd_s rd_out [sps_pkg::SPS_PORTS],
   input sps_pkg::sps_pins_s pins_out [sps_pkg::SPS_PORTS]
);
   import sps_pkg::*;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   sequence s_taken;
      req_take_out[0] ##1 1'b1;
   endsequence
   chk_take_ce: assert property (req_take_out[0] |-> !(&pins_out[0].space_chip_enable_n))
      else $error("no chip enable at take");
   chk_one_space: assert property ($onehot0(~pins_out[0].space_chip_enable_n))
      else $error("two spaces enabled");
   chk_oe_we: assert property (pins_out[0].sync_output_enable_n ||
      pins_out[0].sync_write_enable_n)
      else $error("output and write enable both low");
   chk_read_bus: assert property (!pins_out[0].sync_output_enable_n |->
      !pins_out[0].data_oe)
      else $error("bus driven during read");
   chk_wtake_drive: assert property (wr_data_take_out[0] |-> pins_out[0].data_oe)
      else $error("write word not driven");
   chk_rd_pulse: assert property (rd_out[0].valid |=> !rd_out[0].valid)
      else $error("read valid too long");
   chk_wr_pulse: assert property (wr_data_take_out[0] |=> !wr_data_take_out[0])
      else $error("write take too long");
   chk_take_busy: assert property (s_taken |-> busy_out[0])
      else $error("not busy after take");
   chk_take_idle: assert property (req_take_out[0] |-> !$past(busy_out[0]))
      else $error("take while busy");
endmodule
bind sps_port sps_chk sps_chk_inst(.clk_in(clk_in), .rst_b_in(rst_b_in),
   .req_take_out(req_take_out), .wr_data_take_out(wr_data_take_out),
   .busy_out(busy_out), .rd_out(rd_out), .pins_out(pins_out));

//--- tb/sps_port_tb_top.sv
// Reads and writes on both instances, four settings per instance, one per space.
// Assumes one memory model per port.
`timescale 1ns/1ps
module sps_port_tb_top;
   import sps_pkg::*;
   logic clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic ck1 = 1'b0;
   logic ck2 = 1'b0;
   sps_sec_s sec [SPS_PORTS][SPACES];
   sps_req_s req [SPS_PORTS];
   logic [DATA_W-1:0] wd [SPS_PORTS];
   logic [DATA_W-1:0] rd [SPS_PORTS];
   logic tk [SPS_PORTS];
   logic wtk [SPS_PORTS];
   logic bsy [SPS_PORTS];
   logic csel [SPS_PORTS];
   logic [1:0] rl [SPS_PORTS];
   sps_rd_s ro [SPS_PORTS];
   sps_pins_s pins [SPS_PORTS];
   int fails = 0;
   int checks_done = 0;
   int cyc = 0;
   always #20 clk_in = ~clk_in;
   always #160 ck1 = ~ck1;
   always #213 ck2 = ~ck2;
   sps_port sps_port_inst(.clk_in(clk_in), .rst_b_in(rst_b_in), .ext_clock_out_one_in(ck1),
      .ext_clock_out_two_in(ck2), .space_secondary_control_in(sec), .req_in(req),
      .wr_data_in(wd), .req_take_out(tk), .wr_data_take_out(wtk), .busy_out(bsy),
      .rd_data_in(rd), .rd_out(ro), .pins_out(pins));
   for (genvar g = 0; g < SPS_PORTS; g++)
   begin : g_mem
      sps_mem_model sps_mem_model_inst(.link_clk_in(csel[g] ? ck2 : ck1), .lat_in(rl[g]),
         .pins_in(pins[g]), .rd_data_out(rd[g]));
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("checks_done %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Two-word access to one space; latency counted in selected-clock rises
   task automatic access(input int p, input logic w, input logic [1:0] sp, input sps_sec_s s);
      int rises;
      int first;
      int words;
      int t;
      int idle;
      logic prev;
      logic dsel;
      logic cebad;
      {rises, words, t, idle, dsel, cebad} = '0;
      first = -1;
      sec[p][sp] = s;
      csel[p] = s.sync_clock_select;
      rl[p] = s.read_latency_sel;
      wd[p] = 32'hc0de0000;
      req[p] = '{1'b1, w, sp, 20'h00100, 4'h1};
      while (tk[p] !== 1'b1 && t < 300)
      begin
         @(negedge clk_in);
         t++;
      end
      req[p].valid = 1'b0;
      prev = csel[p] ? ck2 : ck1;
      for (t = 0; t < 300 && idle < 12; t++)
      begin
         if (t > 0)
            @(negedge clk_in);
         idle = (bsy[p] === 1'b1) ? 0 : idle + 1;
         if ((csel[p] ? ck2 : ck1) && !prev)
            rises++;
         prev = csel[p] ? ck2 : ck1;
         if (!pins[p].sync_address_strobe_n && &pins[p].space_chip_enable_n)
            dsel = 1'b1;
         if (s.chip_enable_extend && !w &&
            pins[p].space_chip_enable_n[sp] !== pins[p].sync_output_enable_n)
            cebad = 1'b1;
         // For writes, and for reads without extension, the enable may not outlast the command cycles
         if ((w || !s.chip_enable_extend) && !pins[p].space_chip_enable_n[sp] &&
            (w ? pins[p].sync_write_enable_n : pins[p].sync_address_strobe_n))
            cebad = 1'b1;
         if (w ? wtk[p] === 1'b1 : ro[p].valid === 1'b1)
         begin
            if (first < 0)
               first = rises;
            chk(w ? pins[p].data : ro[p].data,
               w ? wd[p] : {12'h5a0, 20'h00100 + 20'(words)});
            words++;
            wd[p] = wd[p] + 32'h1;
         end
      end
      chk(32'(first),
         w ? 32'(s.write_latency_sel) : 32'(s.read_latency_sel) + 32'h1);
      chk(32'(words), 32'h2);
      chk({31'h0, dsel}, {31'h0, !s.strobe_as_read_enable});
      chk({31'h0, cebad}, 32'h0);
   endtask
   always @(posedge clk_in)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         complete_run();
      end
   end
   initial
   begin
      foreach (sec[a, b])
         sec[a][b] = 7'h7f;
      req = '{default: '0};
      wd = '{default: '0};
      csel = '{default: 1'b0};
      rl = '{default: 2'h0};
      repeat (2) @(negedge clk_in);
      rst_b_in = 1'b1;
      for (int p = 0; p < SPS_PORTS; p++)
      begin
         for (int i = 0; i < 4; i++)
         begin
            access(p, 1'b0, 2'(i), {2'(i), 2'(i), i[0], i[1], i[0]});
            access(p, 1'b1, 2'(i), {2'(i), 2'(i), i[0], i[1], i[0]});
         end
      end
      complete_run();
   end
endmodule
